/* File: hdl/stream_fifo_pkg.sv */
// Purpose: shared constants for the host stream FIFO port
// Assumes: 16-bit host data, single clock domain
// Notes: depth and widths are fixed
package stream_fifo_pkg;
    // =========================================================
    // Sizes
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned PTR_W = 5;
    localparam int unsigned CNT_W = 6;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BASE_W = 4;
    localparam int unsigned OFS_W = 24;
    localparam logic [CNT_W-1:0] FIFO_DEPTH_CNT = 6'h20;

    // =========================================================
    // Host register offsets
    localparam logic [ADDR_W-1:0] BITSTREAM_WRITE_PORT_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] BITSTREAM_FIFO_STATUS_OFS = 8'h62;
    localparam int unsigned STATUS_READY_BIT = 0;

    // =========================================================
    // Burst length codes and word counts
    localparam logic BURST_SEL_EIGHT = 1'b0;
    localparam logic BURST_SEL_SIXTEEN = 1'b1;
    localparam logic [4:0] BURST_WORDS_EIGHT = 5'h08;
    localparam logic [4:0] BURST_WORDS_SIXTEEN = 5'h10;

    // =========================================================
    // Memory transaction types
    typedef enum logic [1:0] {
        MODE_FRAME = 2'b00,
        MODE_FIELD = 2'b01,
        MODE_LINEAR = 2'b10,
        MODE_RESERVED = 2'b11
    } mem_mode_t;

    // Channel state
    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_RUN = 1'b1
    } ch_state_t;

    // =========================================================
    // Values after reset
    localparam logic RST_BURST_SEL = BURST_SEL_SIXTEEN;
    localparam logic [1:0] RST_MODE = 2'b10;
    localparam logic [BASE_W-1:0] RST_BASE = 4'h0;
    localparam logic [CNT_W-1:0] RST_THRESH = 6'h00;
    localparam logic [OFS_W-1:0] RST_OFFSET = 24'h000000;
    localparam logic [PTR_W-1:0] RST_PTR = 5'h00;
    localparam logic [CNT_W-1:0] RST_COUNT = 6'h00;
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
endpackage

/* File: hdl/stream_fifo_ram.sv */
// Purpose: storage for the stream FIFO, registered read data
// Assumes: one clock; read address is the next read pointer
// Notes: write-through bypass keeps an empty FIFO coherent
`timescale 1ns/1ns
module stream_fifo_ram (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [stream_fifo_pkg::PTR_W-1:0] wr_addr_in,
    input wire logic [stream_fifo_pkg::DATA_W-1:0] wr_data_in,
    input wire logic [stream_fifo_pkg::PTR_W-1:0] rd_addr_in,
    output logic [stream_fifo_pkg::DATA_W-1:0] rd_data_out
);
    import stream_fifo_pkg::*;

    logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
    logic [DATA_W-1:0] rd_data_d;
    logic [DATA_W-1:0] rd_data_q;

    // =========================================================
    // Storage array, no reset needed on contents
    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    // Bypass so a word written into the slot being read shows at once
    always_comb begin
        rd_data_d = mem_q[rd_addr_in];
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            rd_data_d = wr_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_q <= RST_DATA;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_out = rd_data_q;
endmodule // stream_fifo_ram

/* File: hdl/host_stream_fifo_port.sv */
// Purpose: host stream FIFO port with DMA request and status flags
// Assumes: host bus strobes are already one-cycle pulses on mclk_in
// Notes: direction and channel settings are taken at channel start
`timescale 1ns/1ns
module host_stream_fifo_port (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [stream_fifo_pkg::ADDR_W-1:0] host_addr_in,
    input wire logic [stream_fifo_pkg::DATA_W-1:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    output logic [stream_fifo_pkg::DATA_W-1:0] host_rdata_out,
    input wire logic host_pop_in,
    output logic [stream_fifo_pkg::DATA_W-1:0] host_pop_data_out,
    output logic host_dma_request_out,
    output logic channel_fifo_flag_out,
    input wire logic channel_start_in,
    input wire logic channel_stop_in,
    input wire logic mem_to_host_in,
    input wire logic [stream_fifo_pkg::CNT_W-1:0] dma_fifo_threshold_in,
    input wire logic [stream_fifo_pkg::CNT_W-1:0] bitstream_threshold_in,
    input wire logic burst_length_sel_in,
    input wire logic [1:0] mem_transaction_type_in,
    input wire logic [stream_fifo_pkg::BASE_W-1:0] partition_base_sel_in,
    input wire logic [stream_fifo_pkg::OFS_W-1:0] source_offset_in,
    input wire logic [stream_fifo_pkg::OFS_W-1:0] destination_offset_in,
    output logic mem_valid_out,
    input wire logic mem_ready_in,
    output logic [stream_fifo_pkg::DATA_W-1:0] mem_data_out,
    input wire logic mem_push_in,
    input wire logic [stream_fifo_pkg::DATA_W-1:0] mem_push_data_in,
    output logic mem_push_ready_out,
    output logic [4:0] burst_words_out,
    output logic [1:0] mem_mode_out,
    output logic [stream_fifo_pkg::BASE_W-1:0] mem_partition_out,
    output logic [stream_fifo_pkg::OFS_W-1:0] mem_offset_out,
    output logic channel_busy_out
);
    import stream_fifo_pkg::*;

    // =========================================================
    // Declarations
    ch_state_t state_q, state_d;
    logic dir_q, dir_d;
    logic burst_q, burst_d;
    logic [1:0] mode_q, mode_d;
    logic [BASE_W-1:0] base_q, base_d;
    logic [CNT_W-1:0] thresh_q, thresh_d;
    logic [OFS_W-1:0] ofs_q, ofs_d;
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [CNT_W-1:0] free_cnt;
    logic full, empty, push, pop, mem_xfer;
    logic [DATA_W-1:0] push_data, ram_rd_data;
    logic chan_flag, status_ready;

    // =========================================================
    // Channel settings, latched at start so a run sees stable values
    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        burst_d = burst_q;
        mode_d = mode_q;
        base_d = base_q;
        thresh_d = thresh_q;
        ofs_d = ofs_q;
        case (state_q)
            CH_IDLE: begin
                if (channel_start_in) begin
                    state_d = CH_RUN;
                    dir_d = mem_to_host_in;
                    burst_d = burst_length_sel_in;
                    // Reserved code falls back to linear access
                    mode_d = (mem_transaction_type_in == MODE_RESERVED) ?
                        MODE_LINEAR : mem_transaction_type_in;
                    base_d = partition_base_sel_in;
                    thresh_d = dma_fifo_threshold_in;
                    ofs_d = mem_to_host_in ? source_offset_in : destination_offset_in;
                end
            end
            CH_RUN: begin
                if (channel_stop_in) begin
                    state_d = CH_IDLE;
                end
                if (mem_xfer) begin
                    ofs_d = OFS_W'(ofs_q + 1'b1);
                end
            end
            default: begin
                state_d = CH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= CH_IDLE;
            dir_q <= 1'b0;
            burst_q <= RST_BURST_SEL;
            mode_q <= RST_MODE;
            base_q <= RST_BASE;
            thresh_q <= RST_THRESH;
            ofs_q <= RST_OFFSET;
        end else begin
            state_q <= state_d;
            dir_q <= dir_d;
            burst_q <= burst_d;
            mode_q <= mode_d;
            base_q <= base_d;
            thresh_q <= thresh_d;
            ofs_q <= ofs_d;
        end
    end

    // =========================================================
    // FIFO push and pop sources depend on direction
    assign full = (count_q == FIFO_DEPTH_CNT);
    assign empty = (count_q == RST_COUNT);
    assign free_cnt = CNT_W'(FIFO_DEPTH_CNT - count_q);
    // Host writes are dropped when full or when memory feeds the FIFO
    assign push = dir_q ? (mem_push_in && !full) :
        (host_wr_in && (host_addr_in == BITSTREAM_WRITE_PORT_OFS) && !full);
    assign push_data = dir_q ? mem_push_data_in : host_wdata_in;
    assign mem_xfer = (state_q == CH_RUN) &&
        (dir_q ? (mem_push_in && !full) : (mem_ready_in && !empty));
    assign pop = dir_q ? (host_pop_in && !empty) : (mem_ready_in && !empty && !dir_q);

    always_comb begin
        wr_ptr_d = push ? PTR_W'(wr_ptr_q + 1'b1) : wr_ptr_q;
        rd_ptr_d = pop ? PTR_W'(rd_ptr_q + 1'b1) : rd_ptr_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = CNT_W'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = CNT_W'(count_q - 1'b1);
        end
    end

    // Host reads only ever return a status or zero, never FIFO data
    always_comb begin
        rdata_d = rdata_q;
        if (host_rd_in) begin
            rdata_d = RST_DATA;
            if (host_addr_in == BITSTREAM_FIFO_STATUS_OFS) begin
                rdata_d[STATUS_READY_BIT] = status_ready;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= RST_PTR;
            rd_ptr_q <= RST_PTR;
            count_q <= RST_COUNT;
            rdata_q <= RST_DATA;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    stream_fifo_ram u_ram (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr_q),
        .wr_data_in(push_data),
        .rd_addr_in(rd_ptr_d),
        .rd_data_out(ram_rd_data)
    );

    // =========================================================
    // Flags straight from occupancy, no extra latency
    assign chan_flag = dir_q ? (count_q > thresh_q) :
        (free_cnt >= thresh_q);
    assign status_ready = !dir_q && (free_cnt >= bitstream_threshold_in);

    assign host_dma_request_out = chan_flag;
    assign channel_fifo_flag_out = chan_flag;
    assign host_rdata_out = rdata_q;
    assign host_pop_data_out = ram_rd_data;
    assign mem_data_out = ram_rd_data;
    assign mem_valid_out = !dir_q && !empty;
    assign mem_push_ready_out = dir_q && !full;
    assign burst_words_out = (burst_q == BURST_SEL_SIXTEEN) ?
        BURST_WORDS_SIXTEEN : BURST_WORDS_EIGHT;
    assign mem_mode_out = mode_q;
    assign mem_partition_out = base_q;
    assign mem_offset_out = ofs_q;
    assign channel_busy_out = (state_q == CH_RUN);

    // =========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    chk_wr_flag_low: assert property (
        !dir_q && (free_cnt < thresh_q) |-> !host_dma_request_out)
        else $error("write request high with too little space");
    chk_rd_flag_low: assert property (
        dir_q && (count_q <= thresh_q) |-> !channel_fifo_flag_out)
        else $error("read flag high with too few words");
    chk_burst_len: assert property (burst_words_out == (burst_q ? 5'h10 : 5'h08))
        else $error("burst length wrong");
    chk_mode_legal: assert property (mem_mode_out != MODE_RESERVED)
        else $error("reserved mode reached memory");
    chk_base_start: assert property (
        (state_q == CH_IDLE) && channel_start_in
        |=> mem_partition_out == $past(partition_base_sel_in))
        else $error("partition not taken at start");
    chk_port_push: assert property (
        !dir_q && host_wr_in && !full && !pop && (host_addr_in == BITSTREAM_WRITE_PORT_OFS)
        |=> count_q == $past(count_q) + 6'h01)
        else $error("port write not pushed");
    chk_port_read: assert property (
        host_rd_in && (host_addr_in == BITSTREAM_WRITE_PORT_OFS)
        |=> host_rdata_out == 16'h0000 && $stable(wr_ptr_q) && $stable(rd_ptr_q))
        else $error("port read not zero or disturbed fifo");
    chk_status_bit: assert property (
        host_rd_in && (host_addr_in == BITSTREAM_FIFO_STATUS_OFS)
        |=> host_rdata_out[0] == $past(status_ready) && host_rdata_out[15:1] == 15'h0000)
        else $error("status read wrong");
    chk_req_high: assert property (
        !dir_q && (free_cnt >= thresh_q) |-> host_dma_request_out)
        else $error("request low with room");
    chk_flag_track: assert property (
        push && !pop ##1 !dir_q |-> channel_fifo_flag_out == (free_cnt >= thresh_q))
        else $error("flag lags occupancy");

    cov_fill_full: cover property (!dir_q ##1 full);
    cov_req_drop: cover property (host_dma_request_out ##1 !host_dma_request_out);
    cov_mem_read: cover property (dir_q && mem_push_in ##[1:4] host_pop_in);
endmodule // host_stream_fifo_port

/* File: tb/host_dma_model.sv */
// Purpose: behavioural external host with a DMA engine
// Assumes: bus signals change by NBA at rising edges of mclk_in
// Notes: released write data and read address show the inverse of the last value
`timescale 1ns/1ns
module host_dma_model (
    input wire logic mclk_in,
    input wire logic dma_request_in,
    input wire logic [stream_fifo_pkg::DATA_W-1:0] rdata_in,
    output logic [stream_fifo_pkg::ADDR_W-1:0] addr_out,
    output logic [stream_fifo_pkg::DATA_W-1:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic pop_out
);
    import stream_fifo_pkg::*;
    // ==========================================================
    // Idle bus
    initial begin
        addr_out = 8'h00;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        pop_out = 1'b0;
    end
    // Words to the port; request is seen one word late, like a real engine
    task automatic send(input logic [15:0] base, input int n, input bit pace);
        int i;
        i = 0;
        while (i < n) begin
            if (pace) begin
                @(negedge mclk_in);
                if (dma_request_in !== 1'b1) break;
            end
            @(posedge mclk_in);
            wr_out <= 1'b1;
            addr_out <= BITSTREAM_WRITE_PORT_OFS;
            wdata_out <= base + i[15:0];
            i++;
        end
        @(posedge mclk_in);
        wr_out <= 1'b0;
        wdata_out <= ~(base + i[15:0] - 16'h0001);
    endtask
    // Register read, data taken once the registered answer settles
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(negedge mclk_in);
        d = rdata_in;
    endtask
    // One word taken from the head in the memory-to-host direction
    task automatic pop();
        @(posedge mclk_in);
        pop_out <= 1'b1;
        @(posedge mclk_in);
        pop_out <= 1'b0;
    endtask
endmodule // host_dma_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for the host stream FIFO port
// Assumes: 25 MHz clock, reset held 10 cycles
// Notes: memory side is driven here, the host side by the model
`timescale 1ns/1ns
module tb;
    import stream_fifo_pkg::*;
    logic mclk_in, rst_n_in, host_wr_in, host_rd_in, host_pop_in;
    logic [7:0] host_addr_in;
    logic [15:0] host_wdata_in, host_rdata_out, host_pop_data_out, mem_data_out;
    logic [15:0] mem_push_data_in, d;
    logic host_dma_request_out, channel_fifo_flag_out, channel_start_in, channel_stop_in;
    logic mem_to_host_in, burst_length_sel_in, mem_valid_out, mem_ready_in, mem_push_in;
    logic mem_push_ready_out, channel_busy_out;
    logic [5:0] dma_fifo_threshold_in, bitstream_threshold_in;
    logic [1:0] mem_transaction_type_in, mem_mode_out;
    logic [3:0] partition_base_sel_in, mem_partition_out;
    logic [23:0] source_offset_in, destination_offset_in, mem_offset_out;
    logic [4:0] burst_words_out;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    host_stream_fifo_port DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
        .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_rdata_out(host_rdata_out),
        .host_pop_in(host_pop_in), .host_pop_data_out(host_pop_data_out),
        .host_dma_request_out(host_dma_request_out),
        .channel_fifo_flag_out(channel_fifo_flag_out), .channel_start_in(channel_start_in),
        .channel_stop_in(channel_stop_in), .mem_to_host_in(mem_to_host_in),
        .dma_fifo_threshold_in(dma_fifo_threshold_in),
        .bitstream_threshold_in(bitstream_threshold_in),
        .burst_length_sel_in(burst_length_sel_in),
        .mem_transaction_type_in(mem_transaction_type_in),
        .partition_base_sel_in(partition_base_sel_in), .source_offset_in(source_offset_in),
        .destination_offset_in(destination_offset_in), .mem_valid_out(mem_valid_out),
        .mem_ready_in(mem_ready_in), .mem_data_out(mem_data_out), .mem_push_in(mem_push_in),
        .mem_push_data_in(mem_push_data_in), .mem_push_ready_out(mem_push_ready_out),
        .burst_words_out(burst_words_out), .mem_mode_out(mem_mode_out),
        .mem_partition_out(mem_partition_out), .mem_offset_out(mem_offset_out),
        .channel_busy_out(channel_busy_out));
    host_dma_model host (.mclk_in(mclk_in), .dma_request_in(host_dma_request_out),
        .rdata_in(host_rdata_out), .addr_out(host_addr_in), .wdata_out(host_wdata_in),
        .wr_out(host_wr_in), .rd_out(host_rd_in), .pop_out(host_pop_in));
    // ==========================================================
    // Clock, timeout and closing report
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Ceiling well above the couple of hundred cycles the tests need
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // ==========================================================
    // Channel control and memory side
    task automatic start(input logic dir, input logic [5:0] thr, input logic bsel,
                         input logic [1:0] mode, input logic [3:0] base);
        @(posedge mclk_in);
        mem_to_host_in <= dir;
        dma_fifo_threshold_in <= thr;
        burst_length_sel_in <= bsel;
        mem_transaction_type_in <= mode;
        partition_base_sel_in <= base;
        channel_start_in <= 1'b1;
        @(posedge mclk_in);
        channel_start_in <= 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic stop();
        @(posedge mclk_in);
        channel_stop_in <= 1'b1;
        @(posedge mclk_in);
        channel_stop_in <= 1'b0;
    endtask
    task automatic drain(input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_in);
            chk_b(mem_valid_out, 1'b1);
            chk_v({8'h00, base + 16'(i)}, {8'h00, mem_data_out});
            @(posedge mclk_in);
            mem_ready_in <= 1'b1;
            @(posedge mclk_in);
            mem_ready_in <= 1'b0;
        end
        @(negedge mclk_in);
    endtask
    task automatic push(input logic [15:0] v);
        @(posedge mclk_in);
        mem_push_in <= 1'b1;
        mem_push_data_in <= v;
        @(posedge mclk_in);
        mem_push_in <= 1'b0;
        mem_push_data_in <= ~v;
        @(negedge mclk_in);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n_in, channel_start_in, channel_stop_in, mem_to_host_in} = 4'h0;
        {mem_ready_in, mem_push_in, burst_length_sel_in} = 3'h0;
        mem_push_data_in = 16'h0000;
        dma_fifo_threshold_in = 6'h00;
        bitstream_threshold_in = 6'h1e;
        mem_transaction_type_in = 2'b00;
        partition_base_sel_in = 4'h0;
        source_offset_in = 24'h000200;
        destination_offset_in = 24'h000100;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(negedge mclk_in);
        chk_v(burst_words_out, 24'h000010);
        chk_v(mem_mode_out, 24'h000002);
        chk_v(mem_partition_out, 24'h000000);
        host.read(BITSTREAM_FIFO_STATUS_OFS, d);
        chk_v(d, 24'h000001);
        host.read(8'h10, d);
        chk_v(d, 24'h000000);
        // Write side: threshold 30, memory stalled
        start(1'b0, 6'h1e, 1'b0, 2'b01, 4'h5);
        chk_b(channel_busy_out, 1'b1);
        chk_v(burst_words_out, 24'h000008);
        chk_v(mem_partition_out, 24'h000005);
        chk_v(mem_offset_out, 24'h000100);
        host.send(16'ha000, 2, 1'b0);
        @(negedge mclk_in);
        chk_b(host_dma_request_out, 1'b1);
        host.send(16'ha002, 1, 1'b0);
        @(negedge mclk_in);
        chk_b(host_dma_request_out, 1'b0);
        chk_b(channel_fifo_flag_out, 1'b0);
        chk_b(mem_push_ready_out, 1'b0);
        host.read(BITSTREAM_FIFO_STATUS_OFS, d);
        chk_v(d, 24'h000000);
        host.read(BITSTREAM_WRITE_PORT_OFS, d);
        chk_v(d, 24'h000000);
        drain(16'ha000, 3);
        chk_b(mem_valid_out, 1'b0);
        chk_v(mem_offset_out, 24'h000103);
        chk_b(host_dma_request_out, 1'b1);
        stop();
        // Every mode and burst code, reserved mode reads as linear
        for (int m = 0; m < 4; m++) begin
            start(1'b0, 6'h01, m[0], m[1:0], 4'(m));
            chk_v(mem_mode_out, (m == 3) ? 24'h2 : 24'(m));
            chk_v(burst_words_out, m[0] ? 24'h10 : 24'h08);
            stop();
        end
        // Paced fill to full, the extra word refused
        start(1'b0, 6'h01, 1'b1, 2'b10, 4'h0);
        host.send(16'hc000, 40, 1'b1);
        @(negedge mclk_in);
        chk_b(channel_fifo_flag_out, 1'b0);
        // Full FIFO: status follows the live threshold
        host.read(BITSTREAM_FIFO_STATUS_OFS, d);
        chk_v(d, 24'h000000);
        @(posedge mclk_in);
        bitstream_threshold_in <= 6'h00;
        host.read(BITSTREAM_FIFO_STATUS_OFS, d);
        chk_v(d, 24'h000001);
        drain(16'hc000, 32);
        chk_b(mem_valid_out, 1'b0);
        stop();
        // Read side: threshold 2
        start(1'b1, 6'h02, 1'b1, 2'b10, 4'h3);
        chk_v(mem_offset_out, 24'h000200);
        chk_b(mem_push_ready_out, 1'b1);
        push(16'hb000);
        push(16'hb001);
        chk_b(host_dma_request_out, 1'b0);
        push(16'hb002);
        chk_b(host_dma_request_out, 1'b1);
        chk_v(host_pop_data_out, 24'h00b000);
        host.pop();
        @(negedge mclk_in);
        chk_v(host_pop_data_out, 24'h00b001);
        chk_b(channel_fifo_flag_out, 1'b0);
        chk_v(mem_offset_out, 24'h000203);
        stop();
        give_verdict();
    end
endmodule // tb
